// ===== design/rcf_defs.vh
// Constants of the remote command frame codec: bytes, offsets, registers.
// Included by the codec; holds definitions only.
`ifndef RCF_DEFS_VH
`define RCF_DEFS_VH
`define RCF_DELIM 8'h7e
`define RCF_T_REMOTE 8'h17
`define RCF_T_LCMD 8'h08
`define RCF_T_LCMDQ 8'h09
`define RCF_T_RSP 8'h88
`define RCF_T_MSTAT 8'h8a
`define RCF_T_TXSTAT 8'h8b
`define RCF_MS_HWRST 8'h00
`define RCF_MS_WDRST 8'h01
`define RCF_MS_WAKE 8'h0b
`define RCF_MS_SLEEP 8'h0c
`define RCF_DLV_OK 8'h00
`define RCF_CST_ERR 8'h01
`define RCF_CST_MAX 3'h4
`define RCF_OPT_APPLY 8'h02
// Frame offsets
`define RCF_OFS_LENH 16'h0001
`define RCF_OFS_LENL 16'h0002
`define RCF_OFS_TYPE 16'h0003
`define RCF_OFS_FID 16'h0004
`define RCF_OFS_ADDR 16'h0005
`define RCF_OFS_ADDR_END 16'h000c
`define RCF_OFS_OPT 16'h000f
`define RCF_OFS_RNAME 16'h0010
`define RCF_OFS_RNAME_END 16'h0011
`define RCF_OFS_RPRM 16'h0012
`define RCF_OFS_LNAME 16'h0005
`define RCF_OFS_LNAME_END 16'h0006
`define RCF_OFS_LPRM 16'h0007
`define RCF_OFS_ONAMEH 16'h0005
`define RCF_OFS_ONAMEL 16'h0006
`define RCF_OFS_OSTAT 16'h0007
`define RCF_OFS_ODATA 16'h0008
`define RCF_OFS_ADRH 16'h0005
`define RCF_OFS_ADRL 16'h0006
`define RCF_OFS_RETRY 16'h0007
`define RCF_OFS_DLV 16'h0008
`define RCF_OFS_DISC 16'h0009
// Body lengths (type byte onward)
`define RCF_LEN_REMOTE_MIN 16'h000f
`define RCF_LEN_LCMD_MIN 16'h0004
`define RCF_LEN_MSTAT 16'h0002
`define RCF_LEN_TXSTAT 16'h0007
`define RCF_LEN_RSP_HDR 16'h0005
`define RCF_HDR_BYTES 16'h0003
// Registers
`define RCF_REG_CTRL 4'h0
`define RCF_REG_ISTAT 4'h4
`define RCF_REG_IMASK 4'h8
`define RCF_REG_ERRCNT 4'hc
`define RCF_CTRL_RST 2'h3
`define RCF_CTRL_RXEN 0
`define RCF_CTRL_TXEN 1
`define RCF_IS_CMD 0
`define RCF_IS_BAD 1
`define RCF_IS_SENT 2
`define RCF_IS_DROP 3
`define RCF_RESP_OKAY 2'h0
`define RCF_RESP_SLVERR 2'h2
`endif

// ===== design/rcf_cksum.v
// Running 8-bit frame checksum: sum of added bytes, shown as 0xff - sum.
// Assumes clr and add come from logic on aclk.
`timescale 1ns/1ns
module rcf_cksum (
  input wire aclk,
  input wire aresetn,
  input wire clr,
  input wire add,
  input wire [7:0] din,
  output wire [7:0] cks
);
  reg [7:0] sum_r;

  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      sum_r <= 8'h00;
    end else if (add) begin
      sum_r <= sum_r + din;
    end
  end

  assign cks = 8'hff - sum_r;
endmodule

// ===== design/rcf_mem.v
// Simple dual-port byte buffer with registered read data.
// Assumes writer and reader share aclk; read data lag the address by one.
`timescale 1ns/1ns
module rcf_mem #(
  parameter DW = 8,
  parameter AW = 6
) (
  input wire aclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== design/rcf_codec.v
// Remote command frame codec: parses host frames, builds device frames.
// Assumes rx bytes and the command/transmit machinery share aclk.
// Function
// - Frame identifier zero suppresses the response
// - Option 0x02 applies at once; others zero
// - Command name sits at bytes 16-17
// - Parameter bytes mean write; none means query
// - Local command answered by type 0x88 frames
// - Response: name 5-6, status 7, data 8
// - Response status codes zero to four
// - Write responses carry no data field
// - Status notification type 0x8A, code offset 4
// - Codes: reset, watchdog, wake, sleep
// - Hardware reset notification after power-up
// - Transmit completion sends type 0x8B frame
// - Broadcast always reports delivery success
// - Transmit status field layout bytes 5-9
// - Delivery status codes passed as given
`timescale 1ns/1ns
`include "rcf_defs.vh"
module rcf_codec #(
  parameter RSP_AW = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  output reg [7:0] tx_byte,
  output reg tx_valid,
  input wire tx_ready,
  output reg cmd_valid,
  output reg cmd_remote,
  output reg [7:0] cmd_fid,
  output reg [63:0] cmd_addr,
  output reg cmd_apply,
  output reg [15:0] cmd_name,
  output reg cmd_write,
  output reg [15:0] cmd_plen,
  output reg prm_valid,
  output reg [7:0] prm_data,
  output reg [15:0] prm_idx,
  input wire rsp_wr_en,
  input wire [RSP_AW-1:0] rsp_wr_addr,
  input wire [7:0] rsp_wr_data,
  input wire rsp_valid,
  output reg rsp_ready,
  input wire [7:0] rsp_fid,
  input wire [15:0] rsp_name,
  input wire [2:0] rsp_status,
  input wire rsp_is_write,
  input wire [RSP_AW:0] rsp_dlen,
  input wire txs_valid,
  output reg txs_ready,
  input wire [7:0] txs_fid,
  input wire [15:0] txs_addr,
  input wire [7:0] txs_retry,
  input wire [7:0] txs_dlv,
  input wire [7:0] txs_disc,
  input wire txs_bcast,
  input wire ev_wdog,
  input wire ev_wake,
  input wire ev_sleep
);
  localparam RX_HUNT = 3'd0;
  localparam RX_LENH = 3'd1;
  localparam RX_LENL = 3'd2;
  localparam RX_BODY = 3'd3;
  localparam RX_CSUM = 3'd4;
  localparam K_MS = 2'd0;
  localparam K_TXS = 2'd1;
  localparam K_RSP = 2'd2;

  reg [1:0] ctrl_r;
  reg [3:0] istat_r;
  reg [3:0] imask_r;
  reg [7:0] errcnt_r;
  reg [3:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg [3:0] ev_set;
  reg [3:0] ist_clr;
  reg [31:0] rd_mux;

  reg [2:0] rx_st_r;
  reg [15:0] rx_len_r;
  reg [15:0] rx_ofs_r;
  reg [7:0] rx_type_r;
  reg [7:0] rx_opt_r;
  reg [15:0] rx_pcnt_r;
  wire [7:0] rx_cks;
  wire rx_remote = (rx_type_r == `RCF_T_REMOTE);
  wire rx_local = (rx_type_r == `RCF_T_LCMD) ||
                  (rx_type_r == `RCF_T_LCMDQ);
  wire rx_start = (rx_st_r == RX_HUNT) && rx_valid &&
                  (rx_byte == `RCF_DELIM) && ctrl_r[`RCF_CTRL_RXEN];
  wire rx_add = (rx_st_r == RX_BODY) && rx_valid;
  wire rx_last = (rx_ofs_r == rx_len_r + `RCF_HDR_BYTES - 16'h0001);

  reg [3:0] ms_pend_r;
  reg [7:0] ms_code_r;
  reg [7:0] txs_fid_r;
  reg [15:0] txs_addr_r;
  reg [7:0] txs_retry_r;
  reg [7:0] txs_dlv_r;
  reg [7:0] txs_disc_r;
  reg [7:0] rsp_fid_r;
  reg [15:0] rsp_name_r;
  reg [7:0] rsp_stat_r;
  reg [RSP_AW:0] rsp_dlen_r;
  reg rsp_wr_r;
  reg tx_busy_r;
  reg tx_wait_r;
  reg [1:0] tx_kind_r;
  reg [15:0] tx_ofs_r;
  reg [15:0] tx_len_r;
  reg [7:0] byte_nxt;
  wire [7:0] tx_cks;
  wire [7:0] mem_rd;
  wire [15:0] mem_ra = tx_ofs_r - `RCF_OFS_ODATA;
  wire [15:0] tx_end = tx_len_r + `RCF_HDR_BYTES;
  wire tx_slot = !tx_valid || tx_ready;
  wire tx_load = tx_busy_r && !tx_wait_r && tx_slot;
  wire tx_done = tx_load && (tx_ofs_r == tx_end);
  wire tx_go = !tx_busy_r && ctrl_r[`RCF_CTRL_TXEN] &&
               ((|ms_pend_r) || !txs_ready || !rsp_ready);
  wire txs_take = txs_valid && txs_ready;
  wire rsp_take = rsp_valid && rsp_ready;

  rcf_cksum u_rx_cks (
    .aclk(aclk), .aresetn(aresetn), .clr(rx_start), .add(rx_add),
    .din(rx_byte), .cks(rx_cks)
  );
  rcf_cksum u_tx_cks (
    .aclk(aclk), .aresetn(aresetn), .clr(tx_go),
    .add(tx_load && (tx_ofs_r >= `RCF_OFS_TYPE) && !tx_done),
    .din(byte_nxt), .cks(tx_cks)
  );
  rcf_mem #(.DW(8), .AW(RSP_AW)) u_rsp_mem (
    .aclk(aclk), .wr_en(rsp_wr_en), .wr_addr(rsp_wr_addr),
    .wr_data(rsp_wr_data), .rd_addr(mem_ra[RSP_AW-1:0]), .rd_data(mem_rd)
  );

  // Register bus: write address and data may arrive in either order
  always @* begin
    ist_clr = 4'h0;
    if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
        aw_addr_r == `RCF_REG_ISTAT && w_strb_r[0]) begin
      ist_clr = w_data_r[3:0];
    end
    case (s_axi_araddr)
      `RCF_REG_CTRL: rd_mux = {30'h0, ctrl_r};
      `RCF_REG_ISTAT: rd_mux = {28'h0, istat_r};
      `RCF_REG_IMASK: rd_mux = {28'h0, imask_r};
      `RCF_REG_ERRCNT: rd_mux = {24'h0, errcnt_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCF_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RCF_RESP_OKAY;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      ctrl_r <= `RCF_CTRL_RST;
      imask_r <= 4'h0;
      istat_r <= 4'h0;
      irq <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RCF_RESP_OKAY;
        if (aw_addr_r == `RCF_REG_CTRL && w_strb_r[0]) begin
          ctrl_r <= w_data_r[1:0];
        end else if (aw_addr_r == `RCF_REG_IMASK && w_strb_r[0]) begin
          imask_r <= w_data_r[3:0];
        end else if (aw_addr_r == `RCF_REG_ERRCNT) begin
          s_axi_bresp <= `RCF_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00) ?
                       `RCF_RESP_OKAY : `RCF_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      // A new event wins over a clear in the same cycle
      istat_r <= (istat_r & ~ist_clr) | ev_set;
      irq <= |(istat_r & imask_r);
    end
  end

  // Receive parser
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r <= RX_HUNT;
      rx_len_r <= 16'h0;
      rx_ofs_r <= 16'h0;
      rx_type_r <= 8'h0;
      rx_opt_r <= 8'h0;
      rx_pcnt_r <= 16'h0;
      errcnt_r <= 8'h0;
      cmd_valid <= 1'b0;
      cmd_remote <= 1'b0;
      cmd_fid <= 8'h0;
      cmd_addr <= 64'h0;
      cmd_apply <= 1'b0;
      cmd_name <= 16'h0;
      cmd_write <= 1'b0;
      cmd_plen <= 16'h0;
      prm_valid <= 1'b0;
      prm_data <= 8'h0;
      prm_idx <= 16'h0;
    end else begin
      cmd_valid <= 1'b0;
      prm_valid <= 1'b0;
      case (rx_st_r)
        RX_HUNT: if (rx_start) begin
          rx_st_r <= RX_LENH;
        end
        RX_LENH: if (rx_valid) begin
          rx_len_r[15:8] <= rx_byte;
          rx_st_r <= RX_LENL;
        end
        RX_LENL: if (rx_valid) begin
          rx_len_r[7:0] <= rx_byte;
          rx_ofs_r <= `RCF_OFS_TYPE;
          rx_pcnt_r <= 16'h0;
          rx_st_r <= (rx_len_r[15:8] == 8'h00 && rx_byte == 8'h00) ?
                     RX_HUNT : RX_BODY;
        end
        RX_BODY: if (rx_valid) begin
          rx_ofs_r <= rx_ofs_r + 16'h0001;
          if (rx_last) rx_st_r <= RX_CSUM;
          if (rx_ofs_r == `RCF_OFS_TYPE) rx_type_r <= rx_byte;
          if (rx_ofs_r == `RCF_OFS_FID) cmd_fid <= rx_byte;
          if (rx_remote) begin
            if (rx_ofs_r >= `RCF_OFS_ADDR && rx_ofs_r <= `RCF_OFS_ADDR_END)
              cmd_addr <= {cmd_addr[55:0], rx_byte};
            if (rx_ofs_r == `RCF_OFS_OPT) rx_opt_r <= rx_byte;
            if (rx_ofs_r == `RCF_OFS_RNAME ||
                rx_ofs_r == `RCF_OFS_RNAME_END)
              cmd_name <= {cmd_name[7:0], rx_byte};
          end else if (rx_local && (rx_ofs_r == `RCF_OFS_LNAME ||
                       rx_ofs_r == `RCF_OFS_LNAME_END)) begin
            cmd_name <= {cmd_name[7:0], rx_byte};
          end
          if ((rx_remote && rx_ofs_r >= `RCF_OFS_RPRM) ||
              (rx_local && rx_ofs_r >= `RCF_OFS_LPRM)) begin
            prm_valid <= 1'b1;
            prm_data <= rx_byte;
            prm_idx <= rx_pcnt_r;
            rx_pcnt_r <= rx_pcnt_r + 16'h0001;
          end
        end
        RX_CSUM: if (rx_valid) begin
          rx_st_r <= RX_HUNT;
          // Bad sums, short frames and stray option bits are refused
          if (rx_byte != rx_cks ||
              (rx_remote && (rx_len_r < `RCF_LEN_REMOTE_MIN ||
               (rx_opt_r & ~`RCF_OPT_APPLY) != 8'h00)) ||
              (rx_local && rx_len_r < `RCF_LEN_LCMD_MIN)) begin
            if (errcnt_r != 8'hff) errcnt_r <= errcnt_r + 8'h01;
          end else if (rx_remote || rx_local) begin
            cmd_valid <= 1'b1;
            cmd_remote <= rx_remote;
            cmd_apply <= rx_remote && rx_opt_r[1];
            cmd_write <= (rx_pcnt_r != 16'h0);
            cmd_plen <= rx_pcnt_r;
          end
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end

  // Outgoing frame bytes by offset
  always @* begin
    byte_nxt = 8'h00;
    if (tx_ofs_r == 16'h0) begin
      byte_nxt = `RCF_DELIM;
    end else if (tx_ofs_r == `RCF_OFS_LENH) begin
      byte_nxt = tx_len_r[15:8];
    end else if (tx_ofs_r == `RCF_OFS_LENL) begin
      byte_nxt = tx_len_r[7:0];
    end else if (tx_ofs_r == tx_end) begin
      byte_nxt = tx_cks;
    end else begin
      case (tx_kind_r)
        K_MS: byte_nxt = (tx_ofs_r == `RCF_OFS_TYPE) ?
                         `RCF_T_MSTAT : ms_code_r;
        K_TXS: case (tx_ofs_r)
          `RCF_OFS_TYPE: byte_nxt = `RCF_T_TXSTAT;
          `RCF_OFS_FID: byte_nxt = txs_fid_r;
          `RCF_OFS_ADRH: byte_nxt = txs_addr_r[15:8];
          `RCF_OFS_ADRL: byte_nxt = txs_addr_r[7:0];
          `RCF_OFS_RETRY: byte_nxt = txs_retry_r;
          `RCF_OFS_DLV: byte_nxt = txs_dlv_r;
          default: byte_nxt = txs_disc_r;
        endcase
        default: case (tx_ofs_r)
          `RCF_OFS_TYPE: byte_nxt = `RCF_T_RSP;
          `RCF_OFS_FID: byte_nxt = rsp_fid_r;
          `RCF_OFS_ONAMEH: byte_nxt = rsp_name_r[15:8];
          `RCF_OFS_ONAMEL: byte_nxt = rsp_name_r[7:0];
          `RCF_OFS_OSTAT: byte_nxt = rsp_stat_r;
          default: byte_nxt = mem_rd;
        endcase
      endcase
    end
  end

  always @* begin
    ev_set = 4'h0;
    ev_set[`RCF_IS_CMD] = (rx_st_r == RX_CSUM) && rx_valid &&
                          (rx_remote || rx_local) && rx_byte == rx_cks;
    ev_set[`RCF_IS_BAD] = (rx_st_r == RX_CSUM) && rx_valid &&
                          rx_byte != rx_cks;
    ev_set[`RCF_IS_SENT] = tx_done;
    ev_set[`RCF_IS_DROP] = (txs_take && txs_fid == 8'h00) ||
                           (rsp_take && rsp_fid == 8'h00);
  end

  // Transmit side: notification first, then transmit status, then reply
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_pend_r <= 4'h1;
      ms_code_r <= 8'h0;
      txs_ready <= 1'b1;
      rsp_ready <= 1'b1;
      txs_fid_r <= 8'h0;
      txs_addr_r <= 16'h0;
      txs_retry_r <= 8'h0;
      txs_dlv_r <= 8'h0;
      txs_disc_r <= 8'h0;
      rsp_fid_r <= 8'h0;
      rsp_name_r <= 16'h0;
      rsp_stat_r <= 8'h0;
      rsp_dlen_r <= {(RSP_AW+1){1'b0}};
      rsp_wr_r <= 1'b0;
      tx_busy_r <= 1'b0;
      tx_wait_r <= 1'b0;
      tx_kind_r <= K_MS;
      tx_ofs_r <= 16'h0;
      tx_len_r <= 16'h0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h0;
    end else begin
      ms_pend_r <= ms_pend_r | {ev_sleep, ev_wake, ev_wdog, 1'b0};
      if (txs_take && txs_fid != 8'h00) begin
        txs_ready <= 1'b0;
        txs_fid_r <= txs_fid;
        txs_addr_r <= txs_addr;
        txs_retry_r <= txs_retry;
        txs_dlv_r <= txs_bcast ? `RCF_DLV_OK : txs_dlv;
        txs_disc_r <= txs_disc;
      end
      if (rsp_take && rsp_fid != 8'h00) begin
        rsp_ready <= 1'b0;
        rsp_fid_r <= rsp_fid;
        rsp_name_r <= rsp_name;
        rsp_stat_r <= (rsp_status > `RCF_CST_MAX) ?
                      `RCF_CST_ERR : {5'h0, rsp_status};
        rsp_dlen_r <= rsp_dlen;
        rsp_wr_r <= rsp_is_write;
      end
      tx_wait_r <= tx_load;
      if (tx_go) begin
        tx_busy_r <= 1'b1;
        tx_ofs_r <= 16'h0;
        if (|ms_pend_r) begin
          tx_kind_r <= K_MS;
          tx_len_r <= `RCF_LEN_MSTAT;
          // Set wins: clearing only the bit being reported
          if (ms_pend_r[0]) begin
            ms_code_r <= `RCF_MS_HWRST;
            ms_pend_r <= {ev_sleep, ev_wake, ev_wdog, 1'b0} |
                         {ms_pend_r[3:1], 1'b0};
          end else if (ms_pend_r[1]) begin
            ms_code_r <= `RCF_MS_WDRST;
            ms_pend_r <= {ev_sleep, ev_wake, ev_wdog, 1'b0} |
                         {ms_pend_r[3:2], 2'b00};
          end else if (ms_pend_r[2]) begin
            ms_code_r <= `RCF_MS_WAKE;
            ms_pend_r <= {ev_sleep, ev_wake, ev_wdog, 1'b0} |
                         {ms_pend_r[3], 3'b000};
          end else begin
            ms_code_r <= `RCF_MS_SLEEP;
            ms_pend_r <= {ev_sleep, ev_wake, ev_wdog, 1'b0};
          end
        end else if (!txs_ready) begin
          tx_kind_r <= K_TXS;
          tx_len_r <= `RCF_LEN_TXSTAT;
        end else begin
          tx_kind_r <= K_RSP;
          tx_len_r <= rsp_wr_r ? `RCF_LEN_RSP_HDR :
                      `RCF_LEN_RSP_HDR +
                      {{(15-RSP_AW){1'b0}}, rsp_dlen_r};
        end
      end
      if (tx_load) begin
        tx_byte <= byte_nxt;
        tx_valid <= 1'b1;
        tx_ofs_r <= tx_ofs_r + 16'h0001;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (tx_done) begin
        tx_busy_r <= 1'b0;
        if (tx_kind_r == K_TXS) txs_ready <= 1'b1;
        if (tx_kind_r == K_RSP) rsp_ready <= 1'b1;
      end
    end
  end
endmodule

// ===== sim/rcf_codec_sva.sv
// Port checker for rcf_codec, bound to every codec instance below.
// Assumes one aclk domain with a synchronous active-low aresetn.
`timescale 1ns/1ns
module rcf_codec_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire [7:0] tx_byte,
  input wire tx_valid,
  input wire tx_ready,
  input wire cmd_valid,
  input wire prm_valid,
  input wire [7:0] prm_data,
  input wire rsp_valid,
  input wire rsp_ready,
  input wire [7:0] rsp_fid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence delim_out;
    tx_valid && tx_byte == 8'h7e;
  endsequence
  write_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  tx_hold_a: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_byte)) else $error("tx byte not held");
  tx_gap_a: assert property (tx_valid && tx_ready
    && $past(!tx_valid || tx_ready) |=> !tx_valid)
    else $error("tx byte without wait cycle");
  param_echo_a: assert property (prm_valid
    |-> $past(rx_valid) && prm_data == $past(rx_byte))
    else $error("parameter byte mismatch");
  cmd_pulse_a: assert property (cmd_valid
    |-> $past(rx_valid) ##1 !cmd_valid) else $error("command pulse bad");
  zero_fid_a: assert property (rsp_valid && rsp_ready
    && rsp_fid == 8'h00 |=> rsp_ready) else $error("zero id not dropped");
  power_note_a: assert property ($rose(aresetn)
    |-> ##[1:3] delim_out) else $error("no frame after reset");
  reset_idle_a: assert property (disable iff (1'b0) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid && !tx_valid && !cmd_valid && !irq)
    else $error("outputs busy in reset");
endmodule

bind rcf_codec rcf_codec_sva u_sva (.*);

// ===== sim/rcf_host_model.sv
// Behavioural host on the serial side: sends frames, collects replies.
// Assumes send is called just after a rising edge of aclk.
`timescale 1ns/1ns
module rcf_host_model (
  input wire aclk,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire [7:0] tx_byte,
  input wire tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic slow;

  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    slow = 1'b0;
  end

  // Slow mode stalls every other cycle
  always @(posedge aclk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_byte);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  task automatic send(input logic [7:0] body[$], input logic bad);
    logic [7:0] s;
    logic [7:0] f[$];
    s = 8'h00;
    foreach (body[i]) s += body[i];
    f = {8'h7e, 8'h00, 8'(body.size()), body};
    f.push_back((8'hff - s) ^ {7'h00, bad});
    foreach (f[i]) begin
      @(posedge aclk);
      rx_byte <= f[i];
      rx_valid <= 1'b1;
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_byte <= ~f[f.size()-1];
  endtask
endmodule

// ===== sim/remote_command_frame_codec_test.sv
// Self-checking bench for rcf_codec with a behavioural host model.
// Assumes codec defaults and a 20 MHz aclk.
`timescale 1ns/1ns
module remote_command_frame_codec_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_arvalid, s_axi_rready, s_axi_rvalid, irq, rx_valid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] rx_byte, tx_byte, cmd_fid, prm_data, rsp_wr_data, rsp_fid;
  logic tx_valid, tx_ready, cmd_valid, cmd_remote, cmd_apply, cmd_write;
  logic [63:0] cmd_addr;
  logic [15:0] cmd_name, cmd_plen, prm_idx, rsp_name, txs_addr, p_idx;
  logic prm_valid, rsp_wr_en, rsp_valid, rsp_ready, rsp_is_write;
  logic [5:0] rsp_wr_addr;
  logic [2:0] rsp_status;
  logic [6:0] rsp_dlen;
  logic txs_valid, txs_ready, txs_bcast, ev_wdog, ev_wake, ev_sleep;
  logic [7:0] txs_fid, txs_retry, txs_dlv, txs_disc, p_data;
  logic [7:0] q[$];
  logic [7:0] dl[6] = '{8'h00, 8'h01, 8'h21, 8'h25, 8'h74, 8'h21};
  int err_count = 0, n_compared = 0, n_cmd = 0;

  rcf_codec DUT (.*);
  rcf_host_model host (.aclk(aclk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (cmd_valid) n_cmd <= n_cmd + 1;
    if (prm_valid) p_data <= prm_data;
    if (prm_valid) p_idx <= prm_idx;
  end

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    finish_test();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) hang();
  endtask

  task automatic rdr(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 40);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) hang();
  endtask

  // Offers a reply (t=0) or transmit status (t=1), held until ready
  task automatic offer(input logic t);
    int n;
    n = 0;
    @(posedge aclk);
    if (t) txs_valid <= 1'b1;
    else rsp_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!(t ? txs_ready : rsp_ready) && n < 400);
    txs_valid <= 1'b0;
    rsp_valid <= 1'b0;
    if (n >= 400) hang();
  endtask

  task automatic expf(input string nm, input logic [7:0] body[$]);
    logic [7:0] s;
    logic [7:0] f[$];
    int n;
    s = 8'h00;
    foreach (body[i]) s += body[i];
    f = {8'h7e, 8'h00, 8'(body.size()), body, 8'hff - s};
    for (n = 0; n < 400 && host.got.size() < f.size(); n++)
      @(posedge aclk);
    if (n >= 400) hang();
    foreach (f[i]) chk(nm, host.got[i], f[i]);
    repeat (f.size()) void'(host.got.pop_front());
  endtask

  initial begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid,
      s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, rsp_wr_en,
      rsp_wr_addr, rsp_wr_data, rsp_valid, rsp_fid, rsp_name, rsp_status,
      rsp_is_write, txs_valid, txs_fid, txs_addr, txs_retry, txs_dlv,
      txs_disc, txs_bcast, ev_wdog, ev_wake, ev_sleep} = '0;
    s_axi_wstrb = 4'hf;
    rsp_dlen = 7'h02;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    expf("hw_note", '{8'h8a, 8'h00});
    rdr(4'h0);
    chk("ctrl", rd, 32'h3);
    rdr(4'h2);
    chk("unaligned", rs, 2'h2);
    wr(4'hc, 32'h5);
    chk("ro_write", rs, 2'h2);
    wr(4'h8, 32'h1);
    host.send('{8'h09, 8'h01, 8'h42, 8'h44}, 1'b0);
    repeat (3) @(posedge aclk);
    chk("local", {n_cmd[1:0], cmd_remote, cmd_write, cmd_fid, cmd_name,
      cmd_plen}, {4'h4, 8'h01, 16'h4244, 16'h0000});
    chk("irq_set", irq, 1'b1);
    rdr(4'h4);
    chk("istat", rd, 32'h5);
    wr(4'h4, 32'h5);
    rdr(4'h4);
    chk("istat_clr", rd, 32'h0);
    chk("irq_clr", irq, 1'b0);
    q = '{8'h17, 8'h01, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h40, 8'h40, 8'h11,
      8'h22, 8'hff, 8'hfe, 8'h02, 8'h42, 8'h48, 8'h01};
    host.send(q, 1'b0);
    repeat (3) @(posedge aclk);
    chk("rem_addr", cmd_addr, 64'h0013a20040401122);
    chk("remote", {cmd_remote, cmd_apply, cmd_write, cmd_name, cmd_plen,
      p_data, p_idx}, {3'b111, 16'h4248, 16'h1, 8'h01, 16'h0});
    host.send('{8'h08, 8'h02, 8'h42, 8'h44}, 1'b1);
    q[12] = 8'h03;
    host.send(q, 1'b0);
    repeat (3) @(posedge aclk);
    chk("refused", n_cmd, 2);
    rdr(4'hc);
    chk("errcnt", rd, 32'h2);
    rsp_wr_en <= 1'b1;
    rsp_wr_data <= 8'haa;
    @(posedge aclk);
    rsp_wr_addr <= 6'h01;
    rsp_wr_data <= 8'h55;
    @(posedge aclk);
    rsp_wr_en <= 1'b0;
    {rsp_fid, rsp_name, rsp_is_write} <= {8'h01, 16'h4244, 1'b1};
    offer(1'b0);
    expf("wr_rsp", '{8'h88, 8'h01, 8'h42, 8'h44, 8'h00});
    host.slow <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      {rsp_fid, rsp_name} <= {8'(8'h10 + i), 8'h52, 8'(8'h30 + i)};
      {rsp_status, rsp_is_write} <= {3'(i), 1'b0};
      offer(1'b0);
      expf("rd_rsp", '{8'h88, 8'(8'h10 + i), 8'h52, 8'(8'h30 + i),
        (i > 4) ? 8'h01 : 8'(i), 8'haa, 8'h55});
    end
    rsp_fid <= 8'h00;
    offer(1'b0);
    repeat (30) @(posedge aclk);
    chk("dropped", host.got.size(), 0);
    rdr(4'h4);
    chk("drop_flag", rd[3], 1'b1);
    for (int i = 0; i < 6; i++) begin
      {txs_fid, txs_addr, txs_retry} <= {8'(8'h20 + i), 8'hff, 8'(i), 8'(i)};
      {txs_dlv, txs_disc, txs_bcast} <= {dl[i], 8'h02, i == 5};
      offer(1'b1);
      expf("tx_stat", '{8'h8b, 8'(8'h20 + i), 8'hff, 8'(i), 8'(i),
        (i == 5) ? 8'h00 : dl[i], 8'h02});
    end
    {ev_wdog, ev_wake, ev_sleep} <= 3'b111;
    @(posedge aclk);
    {ev_wdog, ev_wake, ev_sleep} <= 3'b000;
    expf("wdog", '{8'h8a, 8'h01});
    expf("wake", '{8'h8a, 8'h0b});
    expf("sleep", '{8'h8a, 8'h0c});
    finish_test();
  end
endmodule
